/* rtl/jtc_pkg.sv */
// Shared constants and types of the test access port controller.
package jtc_pkg;

	// Instruction codes.
	localparam logic [3:0] IR_EXTEST = 4'h0;
	localparam logic [3:0] IR_SCAN_N = 4'h2;
	localparam logic [3:0] IR_SAMPLE = 4'h3;
	localparam logic [3:0] IR_RESTART = 4'h4;
	localparam logic [3:0] IR_CLAMP = 4'h5;
	localparam logic [3:0] IR_HIGHZ = 4'h7;
	localparam logic [3:0] IR_FLOAT_CLAMP = 4'h9;
	localparam logic [3:0] IR_INTEST = 4'hc;
	localparam logic [3:0] IR_IDCODE = 4'he;
	localparam logic [3:0] IR_BYPASS = 4'hf;

	// Fixed capture and reset values.
	localparam logic [3:0] IR_CAPTURE_VALUE = 4'h1;
	localparam logic [3:0] IR_RESET_VALUE = IR_IDCODE;
	localparam logic [4:0] SEL_CAPTURE_VALUE = 5'h10;
	localparam logic [4:0] SEL_RESET_VALUE = 5'h03;
	localparam logic [4:0] CHAIN_PRODUCTION = 5'h00;
	localparam logic [4:0] CHAIN_BOUNDARY = 5'h03;
	localparam logic [4:0] CHAIN_EXTERNAL_FIRST = 5'h10;

	// Buffer of the serial output stream.
	localparam int TDO_FIFO_DEPTH = 8;
	localparam int TDO_FIFO_WIDTH = 2;

	// Synchronised pins: trst_n, return data, tdi, tms, tck.
	localparam int SYNC_WIDTH = 5;
	localparam logic [4:0] SYNC_RESET_VALUE = 5'h00;

	// Controller state numbers shown on the state output.
	localparam logic [3:0] NUM_EXIT2_DR = 4'h0;
	localparam logic [3:0] NUM_EXIT1_DR = 4'h1;
	localparam logic [3:0] NUM_SHIFT_DR = 4'h2;
	localparam logic [3:0] NUM_PAUSE_DR = 4'h3;
	localparam logic [3:0] NUM_SELECT_IR = 4'h4;
	localparam logic [3:0] NUM_UPDATE_DR = 4'h5;
	localparam logic [3:0] NUM_CAPTURE_DR = 4'h6;
	localparam logic [3:0] NUM_SELECT_DR = 4'h7;
	localparam logic [3:0] NUM_EXIT2_IR = 4'h8;
	localparam logic [3:0] NUM_EXIT1_IR = 4'h9;
	localparam logic [3:0] NUM_SHIFT_IR = 4'ha;
	localparam logic [3:0] NUM_PAUSE_IR = 4'hb;
	localparam logic [3:0] NUM_IDLE = 4'hc;
	localparam logic [3:0] NUM_UPDATE_IR = 4'hd;
	localparam logic [3:0] NUM_CAPTURE_IR = 4'he;
	localparam logic [3:0] NUM_RESET = 4'hf;

	typedef enum logic [3:0] {
		ST_RESET, ST_IDLE, ST_SELECT_DR, ST_CAPTURE_DR, ST_SHIFT_DR,
		ST_EXIT1_DR, ST_PAUSE_DR, ST_EXIT2_DR, ST_UPDATE_DR,
		ST_SELECT_IR, ST_CAPTURE_IR, ST_SHIFT_IR, ST_EXIT1_IR,
		ST_PAUSE_IR, ST_EXIT2_IR, ST_UPDATE_IR
	} jtc_tap_state_e;

	typedef enum logic [1:0] {
		PATH_BYPASS, PATH_ID, PATH_SELECT, PATH_CHAIN
	} jtc_path_e;

endpackage : jtc_pkg

/* rtl/jtc_sync.sv */
// Three-stage pin synchroniser that passes a change once stages agree.
`timescale 1ns/1ps
`default_nettype none
module jtc_sync #(
	parameter int WIDTH = 5,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	// Clock and reset.
	input wire logic i_core_clk,
	input wire logic i_reset_n,
	// Pins and filtered levels.
	input wire logic [WIDTH-1:0] i_pins,
	output logic [WIDTH-1:0] o_levels
);

	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
		logic [WIDTH-1:0] stage3;
		logic [WIDTH-1:0] level;
	} jtc_sync_s;

	localparam jtc_sync_s RESET_STATE = '{
		stage1: RESET_VALUE, stage2: RESET_VALUE,
		stage3: RESET_VALUE, level: RESET_VALUE};

	jtc_sync_s sync_reg;
	jtc_sync_s sync_next;

	generate
		if (WIDTH < 1)
		begin : g_bad_width
			$error("jtc_sync WIDTH must be at least one");
		end
	endgenerate

	always_comb
	begin
		sync_next = sync_reg;
		sync_next.stage1 = i_pins;
		sync_next.stage2 = sync_reg.stage1;
		sync_next.stage3 = sync_reg.stage2;
		for (int b = 0; b < WIDTH; b++)
		begin
			if (sync_reg.stage2[b] == sync_reg.stage3[b])
			begin
				sync_next.level[b] = sync_reg.stage3[b];
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			sync_reg <= RESET_STATE;
		end
		else
		begin
			sync_reg <= sync_next;
		end
	end

	assign o_levels = sync_reg.level;

endmodule : jtc_sync
`default_nettype wire

/* rtl/jtc_fifo.sv */
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module jtc_fifo #(
	parameter int WIDTH = 2,
	parameter int DEPTH = 8
) (
	// Clock, reset and flush.
	input wire logic i_core_clk,
	input wire logic i_reset_n,
	input wire logic i_clear,
	// Write side.
	input wire logic i_wr_valid,
	input wire logic [WIDTH-1:0] i_wr_data,
	output logic o_wr_ready,
	// Read side.
	output logic o_rd_valid,
	output logic [WIDTH-1:0] o_rd_data,
	input wire logic i_rd_ready
);

	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW:0] wr_ptr;
		logic [AW:0] rd_ptr;
	} jtc_fifo_s;

	jtc_fifo_s fifo_reg;
	jtc_fifo_s fifo_next;
	logic full;
	logic empty;

	generate
		if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
		begin : g_bad_shape
			$error("jtc_fifo DEPTH must be a power of two, WIDTH >= 1");
		end
	endgenerate

	assign empty = (fifo_reg.wr_ptr == fifo_reg.rd_ptr);
	assign full = (fifo_reg.wr_ptr[AW] != fifo_reg.rd_ptr[AW]) &&
		(fifo_reg.wr_ptr[AW-1:0] == fifo_reg.rd_ptr[AW-1:0]);

	always_comb
	begin
		fifo_next = fifo_reg;
		if (i_clear)
		begin
			fifo_next.rd_ptr = fifo_reg.wr_ptr;
		end
		else
		begin
			if (i_wr_valid && !full)
			begin
				fifo_next.mem[fifo_reg.wr_ptr[AW-1:0]] = i_wr_data;
				fifo_next.wr_ptr = fifo_reg.wr_ptr + 1'b1;
			end
			if (i_rd_ready && !empty)
			begin
				fifo_next.rd_ptr = fifo_reg.rd_ptr + 1'b1;
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			fifo_reg <= '0;
		end
		else
		begin
			fifo_reg <= fifo_next;
		end
	end

	assign o_wr_ready = !full;
	assign o_rd_valid = !empty;
	assign o_rd_data = fifo_reg.mem[fifo_reg.rd_ptr[AW-1:0]];

endmodule : jtc_fifo
`default_nettype wire

/* rtl/jtc_tap_scan_control.sv */
// Test access port controller with instruction decode and chain select.
//
// Function
// - Chain select addresses 32 chains; 3 and 16-31 use the external path.
// - The current controller state number appears on a 4-bit output.
// - Test reset acts with no test clock edge at all.
// - Reset puts the boundary cells in system mode.
// - Reset makes the identification instruction current.
// - Instruction register is four bits, captures 0001, no parity.
// - Unassigned instruction codes behave exactly like bypass.
// - Inputs sampled at rising test clock; output changes at falling.
// - External test: chain in test mode, shifted data applied at update.
// - Chain select captures 10000; update selects the chain until next.
// - Select register is five bits; chain 3 selected after reset.
// - Internal test: chain in test mode, capture then shift.
// - Identification: 32-bit code captured and shifted, update no effect.
// - Bypass: one bit, captures zero, delays data one test clock.
// - Clamp: bypass path, outputs held from chain; probe uses chain 0.
// - High-impedance with chain 0 floats outputs, raises indicator.
// - Float clamp with chain 0 disables outputs, data from cells.
// - Sample/preload keeps normal mode; shifted data only fills preload.
// - The selected chain number appears on a 5-bit output.
// - Restart behaves as bypass; pulse on entering run-test/idle.
`timescale 1ns/1ps
`default_nettype none
module jtc_tap_scan_control #(
	// Identification code; the value is arbitrary.
	parameter logic [31:0] ID_CODE = 32'h0000_0001,
	parameter int FIFO_DEPTH = jtc_pkg::TDO_FIFO_DEPTH
) (
	// Core clock and reset.
	input wire logic i_core_clk,
	input wire logic i_reset_n,
	// Test port pins from the probe.
	input wire logic i_tck,
	input wire logic i_tms,
	input wire logic i_tdi,
	input wire logic i_trst_n,
	// Test port serial output.
	output logic o_tdo,
	output logic o_tdo_en,
	// Controller status.
	output logic [3:0] o_tap_state_number,
	output logic [3:0] o_instruction,
	output logic [4:0] o_selected_chain_number,
	// Scan chain serial path.
	output logic o_scan_out,
	input wire logic i_scan_return,
	// Scan cell control.
	output logic o_chain_capture,
	output logic o_chain_shift,
	output logic o_chain_update,
	output logic o_cells_test_mode,
	output logic o_clamp_outputs,
	output logic o_highz,
	output logic o_float_clamp_instruction,
	output logic o_restart
);

	typedef struct packed {
		jtc_pkg::jtc_tap_state_e tap_state;
		logic [3:0] state_number;
		logic [3:0] ir_shift;
		logic [3:0] instruction;
		logic [4:0] select_shift;
		logic [4:0] chain;
		logic [31:0] dr_shift;
		logic tck_prev;
		logic rise_pending;
		logic tms_held;
		logic tdi_held;
		logic ret_held;
		logic push_valid;
		logic [1:0] push_data;
		logic tdo;
		logic tdo_en;
		logic scan_out;
		logic chain_capture;
		logic chain_shift;
		logic chain_update;
		logic cells_test_mode;
		logic clamp_outputs;
		logic highz;
		logic float_clamp;
		logic restart;
	} jtc_core_s;

	localparam jtc_core_s RESET_STATE = '{
		tap_state: jtc_pkg::ST_RESET,
		state_number: jtc_pkg::NUM_RESET,
		instruction: jtc_pkg::IR_RESET_VALUE,
		chain: jtc_pkg::SEL_RESET_VALUE,
		default: '0};

	jtc_core_s core_reg;
	jtc_core_s core_next;
	logic [4:0] pins;
	logic fifo_wr_ready;
	logic fifo_rd_valid;
	logic [1:0] fifo_rd_data;
	logic fifo_rd_ready;
	logic tck_rise;
	logic tck_fall;
	logic trst_active;

	generate
		if (FIFO_DEPTH < 2)
		begin : g_bad_depth
			$error("FIFO_DEPTH must be at least two");
		end
	endgenerate

	jtc_sync #(
		.WIDTH(jtc_pkg::SYNC_WIDTH),
		.RESET_VALUE(jtc_pkg::SYNC_RESET_VALUE)
	) u_sync (
		.i_core_clk(i_core_clk),
		.i_reset_n(i_reset_n),
		.i_pins({i_trst_n, i_scan_return, i_tdi, i_tms, i_tck}),
		.o_levels(pins)
	);

	// Serial output bits wait here between rising and falling test clock.
	jtc_fifo #(
		.WIDTH(jtc_pkg::TDO_FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_tdo_fifo (
		.i_core_clk(i_core_clk),
		.i_reset_n(i_reset_n),
		.i_clear(trst_active),
		.i_wr_valid(core_reg.push_valid),
		.i_wr_data(core_reg.push_data),
		.o_wr_ready(fifo_wr_ready),
		.o_rd_valid(fifo_rd_valid),
		.o_rd_data(fifo_rd_data),
		.i_rd_ready(fifo_rd_ready)
	);

	assign tck_rise = pins[0] && !core_reg.tck_prev;
	assign tck_fall = !pins[0] && core_reg.tck_prev;
	assign trst_active = !pins[4];
	assign fifo_rd_ready = tck_fall;

	function automatic jtc_pkg::jtc_path_e path_of(input logic [3:0] ir);
		case (ir)
			jtc_pkg::IR_EXTEST,
			jtc_pkg::IR_INTEST,
			jtc_pkg::IR_SAMPLE: path_of = jtc_pkg::PATH_CHAIN;
			jtc_pkg::IR_SCAN_N: path_of = jtc_pkg::PATH_SELECT;
			jtc_pkg::IR_IDCODE: path_of = jtc_pkg::PATH_ID;
			default: path_of = jtc_pkg::PATH_BYPASS;
		endcase
	endfunction : path_of

	function automatic jtc_pkg::jtc_tap_state_e step(
		input jtc_pkg::jtc_tap_state_e s, input logic tms);
		case (s)
			jtc_pkg::ST_RESET:
				step = tms ? jtc_pkg::ST_RESET : jtc_pkg::ST_IDLE;
			jtc_pkg::ST_IDLE:
				step = tms ? jtc_pkg::ST_SELECT_DR : jtc_pkg::ST_IDLE;
			jtc_pkg::ST_SELECT_DR:
				step = tms ? jtc_pkg::ST_SELECT_IR : jtc_pkg::ST_CAPTURE_DR;
			jtc_pkg::ST_CAPTURE_DR,
			jtc_pkg::ST_SHIFT_DR:
				step = tms ? jtc_pkg::ST_EXIT1_DR : jtc_pkg::ST_SHIFT_DR;
			jtc_pkg::ST_EXIT1_DR:
				step = tms ? jtc_pkg::ST_UPDATE_DR : jtc_pkg::ST_PAUSE_DR;
			jtc_pkg::ST_PAUSE_DR:
				step = tms ? jtc_pkg::ST_EXIT2_DR : jtc_pkg::ST_PAUSE_DR;
			jtc_pkg::ST_EXIT2_DR:
				step = tms ? jtc_pkg::ST_UPDATE_DR : jtc_pkg::ST_SHIFT_DR;
			jtc_pkg::ST_SELECT_IR:
				step = tms ? jtc_pkg::ST_RESET : jtc_pkg::ST_CAPTURE_IR;
			jtc_pkg::ST_CAPTURE_IR,
			jtc_pkg::ST_SHIFT_IR:
				step = tms ? jtc_pkg::ST_EXIT1_IR : jtc_pkg::ST_SHIFT_IR;
			jtc_pkg::ST_EXIT1_IR:
				step = tms ? jtc_pkg::ST_UPDATE_IR : jtc_pkg::ST_PAUSE_IR;
			jtc_pkg::ST_PAUSE_IR:
				step = tms ? jtc_pkg::ST_EXIT2_IR : jtc_pkg::ST_PAUSE_IR;
			jtc_pkg::ST_EXIT2_IR:
				step = tms ? jtc_pkg::ST_UPDATE_IR : jtc_pkg::ST_SHIFT_IR;
			jtc_pkg::ST_UPDATE_DR,
			jtc_pkg::ST_UPDATE_IR:
				step = tms ? jtc_pkg::ST_SELECT_DR : jtc_pkg::ST_IDLE;
			default:
				step = jtc_pkg::ST_RESET;
		endcase
	endfunction : step

	function automatic logic [3:0] number_of(
		input jtc_pkg::jtc_tap_state_e s);
		case (s)
			jtc_pkg::ST_RESET: number_of = jtc_pkg::NUM_RESET;
			jtc_pkg::ST_IDLE: number_of = jtc_pkg::NUM_IDLE;
			jtc_pkg::ST_SELECT_DR: number_of = jtc_pkg::NUM_SELECT_DR;
			jtc_pkg::ST_CAPTURE_DR: number_of = jtc_pkg::NUM_CAPTURE_DR;
			jtc_pkg::ST_SHIFT_DR: number_of = jtc_pkg::NUM_SHIFT_DR;
			jtc_pkg::ST_EXIT1_DR: number_of = jtc_pkg::NUM_EXIT1_DR;
			jtc_pkg::ST_PAUSE_DR: number_of = jtc_pkg::NUM_PAUSE_DR;
			jtc_pkg::ST_EXIT2_DR: number_of = jtc_pkg::NUM_EXIT2_DR;
			jtc_pkg::ST_UPDATE_DR: number_of = jtc_pkg::NUM_UPDATE_DR;
			jtc_pkg::ST_SELECT_IR: number_of = jtc_pkg::NUM_SELECT_IR;
			jtc_pkg::ST_CAPTURE_IR: number_of = jtc_pkg::NUM_CAPTURE_IR;
			jtc_pkg::ST_SHIFT_IR: number_of = jtc_pkg::NUM_SHIFT_IR;
			jtc_pkg::ST_EXIT1_IR: number_of = jtc_pkg::NUM_EXIT1_IR;
			jtc_pkg::ST_PAUSE_IR: number_of = jtc_pkg::NUM_PAUSE_IR;
			jtc_pkg::ST_EXIT2_IR: number_of = jtc_pkg::NUM_EXIT2_IR;
			jtc_pkg::ST_UPDATE_IR: number_of = jtc_pkg::NUM_UPDATE_IR;
			default: number_of = jtc_pkg::NUM_RESET;
		endcase
	endfunction : number_of

	always_comb
	begin
		logic tms;
		logic tdi;
		logic ret;
		logic slot_free;
		logic chain_zero;
		jtc_pkg::jtc_path_e path;
		tms = tck_rise ? pins[1] : core_reg.tms_held;
		tdi = tck_rise ? pins[2] : core_reg.tdi_held;
		ret = tck_rise ? pins[3] : core_reg.ret_held;
		slot_free = !core_reg.push_valid || fifo_wr_ready;
		path = path_of(core_reg.instruction);
		chain_zero = 1'b0;
		core_next = core_reg;
		core_next.tck_prev = pins[0];
		core_next.chain_capture = 1'b0;
		core_next.chain_shift = 1'b0;
		core_next.chain_update = 1'b0;
		core_next.restart = 1'b0;
		if (tck_rise)
		begin
			core_next.tms_held = pins[1];
			core_next.tdi_held = pins[2];
			core_next.ret_held = pins[3];
			core_next.rise_pending = 1'b1;
		end
		if (core_reg.push_valid && fifo_wr_ready)
		begin
			core_next.push_valid = 1'b0;
		end
		// A full buffer holds the edge back until room appears.
		if (core_next.rise_pending && slot_free)
		begin
			core_next.rise_pending = 1'b0;
			core_next.tap_state = step(core_reg.tap_state, tms);
			case (core_reg.tap_state)
				jtc_pkg::ST_CAPTURE_IR:
				begin
					core_next.ir_shift = jtc_pkg::IR_CAPTURE_VALUE;
				end
				jtc_pkg::ST_SHIFT_IR:
				begin
					core_next.ir_shift = {tdi, core_reg.ir_shift[3:1]};
				end
				jtc_pkg::ST_UPDATE_IR:
				begin
					core_next.instruction = core_reg.ir_shift;
				end
				jtc_pkg::ST_CAPTURE_DR:
				begin
					case (path)
						jtc_pkg::PATH_ID:
						begin
							core_next.dr_shift = ID_CODE;
						end
						jtc_pkg::PATH_SELECT:
						begin
							core_next.select_shift = jtc_pkg::SEL_CAPTURE_VALUE;
						end
						jtc_pkg::PATH_CHAIN:
						begin
							core_next.chain_capture = 1'b1;
						end
						default:
						begin
							core_next.dr_shift[0] = 1'b0;
						end
					endcase
				end
				jtc_pkg::ST_SHIFT_DR:
				begin
					case (path)
						jtc_pkg::PATH_ID:
						begin
							core_next.dr_shift = {tdi, core_reg.dr_shift[31:1]};
						end
						jtc_pkg::PATH_SELECT:
						begin
							core_next.select_shift =
								{tdi, core_reg.select_shift[4:1]};
						end
						jtc_pkg::PATH_CHAIN:
						begin
							core_next.scan_out = tdi;
							core_next.chain_shift = 1'b1;
						end
						default:
						begin
							core_next.dr_shift[0] = tdi;
						end
					endcase
				end
				jtc_pkg::ST_UPDATE_DR:
				begin
					if (path == jtc_pkg::PATH_SELECT)
					begin
						core_next.chain = core_reg.select_shift;
					end
					else if (path == jtc_pkg::PATH_CHAIN)
					begin
						core_next.chain_update = 1'b1;
					end
				end
				default:
				begin
				end
			endcase
			if (core_next.tap_state == jtc_pkg::ST_RESET)
			begin
				core_next.instruction = jtc_pkg::IR_RESET_VALUE;
				core_next.chain = jtc_pkg::SEL_RESET_VALUE;
			end
			if (core_next.tap_state == jtc_pkg::ST_IDLE &&
				core_reg.tap_state != jtc_pkg::ST_IDLE &&
				core_next.instruction == jtc_pkg::IR_RESTART)
			begin
				core_next.restart = 1'b1;
			end
			core_next.push_valid = 1'b1;
			core_next.push_data = 2'h0;
			if (core_next.tap_state == jtc_pkg::ST_SHIFT_IR)
			begin
				core_next.push_data = {1'b1, core_next.ir_shift[0]};
			end
			else if (core_next.tap_state == jtc_pkg::ST_SHIFT_DR)
			begin
				case (path)
					jtc_pkg::PATH_SELECT:
						core_next.push_data = {1'b1, core_next.select_shift[0]};
					jtc_pkg::PATH_CHAIN:
						core_next.push_data = {1'b1, ret};
					default:
						core_next.push_data = {1'b1, core_next.dr_shift[0]};
				endcase
			end
		end
		if (tck_fall && fifo_rd_valid)
		begin
			core_next.tdo_en = fifo_rd_data[1];
			core_next.tdo = fifo_rd_data[0];
		end
		// Test reset needs no test clock.
		if (trst_active)
		begin
			core_next = RESET_STATE;
			core_next.tck_prev = pins[0];
		end
		chain_zero = (core_next.chain == jtc_pkg::CHAIN_PRODUCTION);
		// Cells in system mode unless testing.
		core_next.cells_test_mode =
			(core_next.instruction == jtc_pkg::IR_EXTEST) ||
			(core_next.instruction == jtc_pkg::IR_INTEST);
		core_next.clamp_outputs =
			(core_next.instruction == jtc_pkg::IR_CLAMP) ||
			(core_next.instruction == jtc_pkg::IR_FLOAT_CLAMP && chain_zero);
		core_next.highz =
			(core_next.instruction == jtc_pkg::IR_HIGHZ) && chain_zero;
		core_next.float_clamp =
			(core_next.instruction == jtc_pkg::IR_FLOAT_CLAMP) && chain_zero;
		core_next.state_number = number_of(core_next.tap_state);
	end

	always_ff @(posedge i_core_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			core_reg <= RESET_STATE;
		end
		else
		begin
			core_reg <= core_next;
		end
	end

	assign o_tdo = core_reg.tdo;
	assign o_tdo_en = core_reg.tdo_en;
	assign o_tap_state_number = core_reg.state_number;
	assign o_instruction = core_reg.instruction;
	assign o_selected_chain_number = core_reg.chain;
	assign o_scan_out = core_reg.scan_out;
	assign o_chain_capture = core_reg.chain_capture;
	assign o_chain_shift = core_reg.chain_shift;
	assign o_chain_update = core_reg.chain_update;
	assign o_cells_test_mode = core_reg.cells_test_mode;
	assign o_clamp_outputs = core_reg.clamp_outputs;
	assign o_highz = core_reg.highz;
	assign o_float_clamp_instruction = core_reg.float_clamp;
	assign o_restart = core_reg.restart;

endmodule : jtc_tap_scan_control
`default_nettype wire

/* dv/jtc_probe.sv */
// Behavioural debug probe that drives the test port pins.
`timescale 1ns/1ps
`default_nettype none
module jtc_probe (
	// Pins towards the controller.
	output logic o_tck,
	output logic o_tms,
	output logic o_tdi,
	output logic o_trst_n,
	// Serial data back from the controller.
	input wire logic i_tdo
);
	initial
	begin
		o_tck = 1'b0;
		o_tms = 1'b1;
		o_tdi = 1'b0;
		o_trst_n = 1'b0;
	end
	task automatic rst();
	begin
		o_trst_n = 1'b0;
		#100;
		o_trst_n = 1'b1;
		#100;
	end
	endtask : rst
	// change after fall.
	// The long low phase lets the buffered serial output settle.
	task automatic io(input logic tms, input logic tdi, output logic tdo);
	begin
		o_tms = tms;
		o_tdi = tdi;
		#85;
		tdo = i_tdo;
		o_tck = 1'b1;
		#40;
		o_tck = 1'b0;
	end
	endtask : io
endmodule : jtc_probe
`default_nettype wire

/* dv/jtc_chk.sv */
// Port checker of the test access port controller.
`timescale 1ns/1ps
`default_nettype none
module jtc_chk (
	// Clock, reset and watched ports.
	input wire logic i_core_clk,
	input wire logic i_reset_n,
	input wire logic i_tck,
	input wire logic i_trst_n,
	input wire logic o_tdo,
	input wire logic [3:0] o_tap_state_number,
	input wire logic [3:0] o_instruction,
	input wire logic [4:0] o_selected_chain_number,
	input wire logic o_chain_capture,
	input wire logic o_chain_shift,
	input wire logic o_chain_update,
	input wire logic o_cells_test_mode,
	input wire logic o_clamp_outputs,
	input wire logic o_highz,
	input wire logic o_float_clamp_instruction,
	input wire logic o_restart
);
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_reset_n);
	a_trst_state: assert property (
		(!i_trst_n) [*6] |-> o_tap_state_number == 4'hf &&
		o_instruction == 4'he && o_selected_chain_number == 5'h03)
		else $error("test reset values wrong");
	a_reset_mode: assert property (
		(!i_trst_n) [*6] |-> !o_cells_test_mode && !o_highz &&
		!o_clamp_outputs)
		else $error("cells not in system mode");
	a_test_mode: assert property (
		o_cells_test_mode == (o_instruction == 4'h0 ||
		o_instruction == 4'hc))
		else $error("test mode decode wrong");
	a_highz_mode: assert property (
		o_highz == (o_instruction == 4'h7 &&
		o_selected_chain_number == 5'h00))
		else $error("float indicator wrong");
	a_float_mode: assert property (
		o_float_clamp_instruction == (o_instruction == 4'h9 &&
		o_selected_chain_number == 5'h00))
		else $error("float clamp decode wrong");
	a_clamp_mode: assert property (
		o_clamp_outputs == (o_instruction == 4'h5 ||
		o_float_clamp_instruction))
		else $error("clamp decode wrong");
	a_strobe_gate: assert property (
		o_chain_capture || o_chain_shift || o_chain_update |->
		o_instruction inside {4'h0, 4'h3, 4'hc})
		else $error("chain strobe under wrong instruction");
	a_capture_time: assert property (
		o_chain_capture |-> $past(o_tap_state_number) == 4'h6)
		else $error("capture strobe outside capture");
	a_restart_pulse: assert property (
		o_restart |-> o_tap_state_number == 4'hc &&
		o_instruction == 4'h4 && $past(o_tap_state_number) != 4'hc)
		else $error("restart pulse wrong");
	a_chain_hold: assert property (
		$changed(o_selected_chain_number) |->
		o_instruction == 4'h2 || o_selected_chain_number == 5'h03)
		else $error("chain changed without select");
	a_tdo_falls: assert property (
		$changed(o_tdo) && i_trst_n |-> !i_tck && !$past(i_tck, 2))
		else $error("serial output changed off falling edge");
	c_capture: cover property (o_chain_capture);
	c_restart: cover property (o_restart);
	c_highz: cover property (o_highz);
endmodule : jtc_chk
bind jtc_tap_scan_control jtc_chk chk_u (
	.i_core_clk, .i_reset_n, .i_tck, .i_trst_n, .o_tdo,
	.o_tap_state_number, .o_instruction, .o_selected_chain_number,
	.o_chain_capture, .o_chain_shift, .o_chain_update,
	.o_cells_test_mode, .o_clamp_outputs, .o_highz,
	.o_float_clamp_instruction, .o_restart);
`default_nettype wire

/* dv/jtc_tap_scan_control_tb_top.sv */
// Self-checking bench of the test access port controller.
`timescale 1ns/1ps
`default_nettype none
module jtc_tap_scan_control_tb_top;
	// Identification value; arbitrary.
	localparam logic [31:0] ID = 32'h5a3c_0f01;
	logic clk = 1'b0;
	logic rst_n;
	logic tck, tms, tdi, trst_n, tdo, so, en;
	logic [3:0] st, ir;
	logic [4:0] ch;
	logic cap, sh, up, tm, cl, hz, fc, rs;
	int num_errors = 0;
	int tests_run = 0;
	int n_rs = 0;
	int n_sh = 0;
	int n_cu = 0;
	always #5 clk = ~clk;
	// Counts the one-cycle strobes, which the tasks cannot catch directly.
	always @(posedge clk)
	begin
		n_rs <= n_rs + int'(rs === 1'b1);
		n_sh <= n_sh + int'(sh === 1'b1);
		n_cu <= n_cu + int'(cap === 1'b1) + int'(up === 1'b1);
	end
	// The scan chain is modelled as a wire looping data back.
	jtc_tap_scan_control #(.ID_CODE(ID)) dut_u (
		.i_core_clk(clk), .i_reset_n(rst_n), .i_tck(tck), .i_tms(tms),
		.i_tdi(tdi), .i_trst_n(trst_n), .o_tdo(tdo), .o_tdo_en(en),
		.o_tap_state_number(st), .o_instruction(ir),
		.o_selected_chain_number(ch), .o_scan_out(so), .i_scan_return(so),
		.o_chain_capture(cap), .o_chain_shift(sh), .o_chain_update(up),
		.o_cells_test_mode(tm), .o_clamp_outputs(cl), .o_highz(hz),
		.o_float_clamp_instruction(fc), .o_restart(rs));
	jtc_probe p_u (.o_tck(tck), .o_tms(tms), .o_tdi(tdi),
		.o_trst_n(trst_n), .i_tdo(tdo));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
	begin
		tests_run++;
		if (got !== exp)
			$display("CHECK FAILED at %0t: got %h, want %h", $time, got, exp);
		if (got !== exp)
			num_errors++;
	end
	endtask : chk
	task automatic mv(input logic [7:0] t, input int n);
		logic b;
	begin
		for (int i = 0; i < n; i++)
			p_u.io(t[i], 1'b0, b);
	end
	endtask : mv
	// Shifts LSB first from a shift state, then updates and idles.
	task automatic shf(input logic [31:0] v, input int n,
		output logic [31:0] d);
	begin
		d = '0;
		for (int i = 0; i < n; i++)
			p_u.io(i == n - 1, v[i], d[i]);
		mv(8'h01, 2);
		repeat (10) @(posedge clk);
		#1;
	end
	endtask : shf
	task automatic dr(input logic [31:0] v, input int n,
		output logic [31:0] d);
	begin
		mv(8'h01, 3);
		shf(v, n, d);
	end
	endtask : dr
	task automatic ld(input logic [3:0] c, output logic [31:0] d);
	begin
		mv(8'h03, 4);
		shf({28'h0, c}, 4, d);
	end
	endtask : ld
	task automatic t_reset();
		logic [31:0] d;
	begin
		p_u.rst();
		mv(8'h00, 1);
		ld(4'hf, d);
		chk(d, 32'h1);
		mv(8'h01, 3);
		repeat (10) @(posedge clk);
		#1;
		chk(st, 4'h2);
		chk(en, 1'b1);
		p_u.rst();
		chk(st, 4'hf);
		chk(en, 1'b0);
		chk(ir, 4'he);
		chk(ch, 5'h03);
		chk(tm, 1'b0);
		mv(8'h00, 1);
		dr(32'h0, 32, d);
		chk(d, ID);
		$display("t_reset done");
	end
	endtask : t_reset
	task automatic t_bypass();
		logic [31:0] d;
		logic [3:0] c [8] = '{4'hf, 4'h1, 4'h4, 4'h6, 4'h8, 4'ha, 4'hb, 4'hd};
	begin
		foreach (c[i])
		begin
			ld(c[i], d);
			dr(32'hb5, 9, d);
			chk(d, 32'h16a);
			chk(tm, 1'b0);
		end
		chk(n_rs, 2);
		$display("t_bypass done");
	end
	endtask : t_bypass
	task automatic t_scan();
		logic [31:0] d;
		logic [3:0] c [3] = '{4'h7, 4'h9, 4'h5};
		logic [2:0] e [3] = '{3'h4, 3'h3, 3'h1};
	begin
		ld(4'h2, d);
		dr(32'h0, 5, d);
		chk(d, 32'h10);
		chk(ch, 5'h00);
		foreach (c[i])
		begin
			ld(c[i], d);
			chk({hz, fc, cl}, e[i]);
			dr(32'h1, 2, d);
			chk(d, 32'h2);
		end
		ld(4'h2, d);
		dr(32'h11, 5, d);
		chk(ch, 5'h11);
		ld(4'h7, d);
		chk(hz, 1'b0);
		$display("t_scan done");
	end
	endtask : t_scan
	task automatic t_ext();
		logic [31:0] d;
	begin
		ld(4'h3, d);
		dr(32'ha5, 8, d);
		chk(d, 32'h94);
		chk(tm, 1'b0);
		ld(4'h0, d);
		chk(tm, 1'b1);
		dr(32'h3c, 8, d);
		chk(d, 32'hf3);
		ld(4'hc, d);
		chk(tm, 1'b1);
		dr(32'h3c, 8, d);
		chk(d, 32'hf0);
		chk(n_sh, 24);
		chk(n_cu, 6);
		$display("t_ext done");
	end
	endtask : t_ext
	task automatic t_tms5();
	begin
		mv(8'h01, 3);
		mv(8'h1f, 5);
		repeat (10) @(posedge clk);
		#1;
		chk(st, 4'hf);
		chk(ir, 4'he);
		chk(ch, 5'h03);
		$display("t_tms5 done");
	end
	endtask : t_tms5
	task automatic end_sim();
	begin
		$display("checks %0d, errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	end
	endtask : end_sim
	initial
	begin
		rst_n = 1'b0;
		repeat (10) @(posedge clk);
		#1 rst_n = 1'b1;
		t_reset();
		t_bypass();
		t_scan();
		t_ext();
		t_tms5();
		end_sim();
	end
	initial
	begin
		#400000;
		num_errors++;
		end_sim();
	end
endmodule : jtc_tap_scan_control_tb_top
`default_nettype wire
